// *** core/swsc_slot.v ***
// single-wire slave slot engine with crc-16 framing
// Function
// - each slot carries exactly one bit, write or read
// - falling edge starts the internal slot timer that sets sampling
// - slave needs recovery after rising edge before next slot
// - zero reply: slave pulls low in read window until timer ends
// - one reply: slave never pulls the line low
// - extra falling-edge filtering at standard speed, none at overdrive
// - lows inside rising-edge holdoff ignored; longer lows start a slot
// - identity top byte is crc-8 over first 56 bits, true form
// - crc-16 x^16+x^15+x^2+1, always sent complemented
// - first crc memory read pass: clear, then command, address, data
// - password bytes never enter the crc-16
// - later memory read passes: clear, then that pass's data only
// - scratchpad write crc: command, both address bytes, data
// - scratchpad write crc sent only on reaching offset 11111b
// - scratchpad read crc: command, address, status byte, data
// - scratchpad read crc sent only when reading reaches last offset
// - standard timing unless fast speed selected; fast applies to all
// - reset low >=690us leaves fast speed; <=80us keeps it
`timescale 1ns/10ps
module swsc_slot (
	input  wire       i_clk,
	input  wire       i_srst,
	input  wire       i_dq_in,
	output wire       o_dq_out,
	output wire       o_dq_oe_n,
	input  wire       i_fast_speed_set,
	output wire       o_fast_speed_flag,
	output wire       o_reset_seen,
	output reg        o_wbit_valid,
	output reg        o_wbit,
	input  wire       i_tx_valid,
	output wire       o_tx_ready,
	input  wire [7:0] i_tx_byte,
	output reg        o_tx_busy,
	input  wire       i_crc_start,
	input  wire [1:0] i_crc_kind,
	input  wire       i_crc_byte_valid,
	input  wire [7:0] i_crc_byte,
	input  wire       i_crc_is_pw,
	input  wire [4:0] i_sp_offset,
	input  wire       i_crc_send,
	output reg        o_crc_sent
);
	`include "swsc_defs.vh"

	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_FILT = 3'd1;
	localparam [2:0] ST_LOW  = 3'd2;
	localparam [2:0] ST_REC  = 3'd3;
	localparam [2:0] ST_REH  = 3'd4;

	// cycle counts cut to the timer width on purpose
	localparam [15:0] FILT_CYC  = `SWSC_STD_FILT_CYC;
	localparam [15:0] FILT_LAST = `SWSC_STD_FILT_CYC - 1;
	localparam [15:0] STD_SMP   = `SWSC_STD_SAMPLE_CYC;
	localparam [15:0] OD_SMP    = `SWSC_OD_SAMPLE_CYC;
	localparam [15:0] STD_END   = `SWSC_STD_SAMPLE_CYC + `SWSC_STD_HOLD_CYC;
	localparam [15:0] OD_END    = `SWSC_OD_SAMPLE_CYC + `SWSC_OD_HOLD_CYC;
	localparam [15:0] STD_REH   = `SWSC_STD_REH_CYC;
	localparam [15:0] OD_REH    = `SWSC_OD_REH_CYC;
	localparam [15:0] RST_CYC   = `SWSC_RST_EXIT_CYC;

	reg  [2:0]  state_ff;
	reg  [2:0]  nxt_state;
	reg  [15:0] tmr_ff;
	reg  [15:0] nxt_tmr;
	reg         fast_ff;
	reg         drive_ff;
	reg  [7:0]  sh_ff;
	reg  [2:0]  bitn_ff;
	reg         sh_full_ff;
	reg         crc_act_ff;
	reg  [1:0]  kind_ff;
	wire [15:0] end_cyc;
	reg  [1:0]  crc_left_ff;
	reg  [7:0]  crc_hi_ff;
	reg         rst_rep_ff;
	wire [15:0] crc_val;
	wire        fifo_rvalid;
	wire [7:0]  fifo_rdata;
	wire        load_sh;
	wire        sample_pt;
	wire        slot_end;
	wire        crc_clear;
	wire        crc_shift;
	wire        crc_due;

	// speed-dependent counts; the fast flag picks overdrive counts, otherwise standard ones
	function [15:0] sel_cyc;
		input        fast;
		input [15:0] std_c;
		input [15:0] od_c;
		begin
			sel_cyc = fast ? od_c : std_c;
		end
	endfunction

	// outgoing bytes queue up ahead of the bit shifter
	swsc_fifo #(
		.WIDTH (`SWSC_FIFO_W),
		.DEPTH (`SWSC_FIFO_D),
		.AW    (`SWSC_FIFO_AW)
	) u_fifo (
		.i_clk    (i_clk),
		.i_srst   (i_srst),
		.i_wvalid (i_tx_valid),
		.o_wready (o_tx_ready),
		.i_wdata  (i_tx_byte),
		.o_rvalid (fifo_rvalid),
		.i_rready (load_sh),
		.o_rdata  (fifo_rdata)
	);

	// crc generator shared by all sessions
	swsc_crc16 u_crc (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_clear (crc_clear),
		.i_shift (crc_shift),
		.i_byte  (i_crc_byte),
		.o_crc   (crc_val)
	);

	assign o_dq_out          = 1'b0;
	assign o_dq_oe_n         = ~drive_ff;
	assign o_fast_speed_flag = fast_ff;
	assign o_reset_seen      = rst_rep_ff;

	// sample point and end of slot measured from the falling edge
	assign end_cyc   = sel_cyc(fast_ff, STD_END, OD_END);
	assign sample_pt = (state_ff == ST_LOW) & (tmr_ff == sel_cyc(fast_ff,
		STD_SMP, OD_SMP));
	// a write-one releases early, so the slot only ends on the timer
	assign slot_end  = (state_ff == ST_LOW) & i_dq_in & ~drive_ff
		& (tmr_ff >= end_cyc);

	// a fresh byte loads when the shifter runs dry between slots
	assign load_sh = ~sh_full_ff & fifo_rvalid & (crc_left_ff == 2'd0)
		& (state_ff == ST_IDLE);

	// session start clears; passwords skipped; header only on first pass
	assign crc_clear = i_crc_start;
	// later passes see only data bytes, so every byte offered counts
	assign crc_shift = i_crc_byte_valid & crc_act_ff
		& ~i_crc_is_pw;

	// scratchpad crc only once the last offset is covered
	assign crc_due = i_crc_send & crc_act_ff & (crc_left_ff == 2'd0)
		& (state_ff == ST_IDLE)
		& (((kind_ff == `SWSC_K_WS) | (kind_ff == `SWSC_K_RS))
		? (i_sp_offset == `SWSC_SP_LAST) : 1'b1);

	// slot state machine
	always @* begin
		nxt_state = state_ff;
		nxt_tmr   = tmr_ff + 16'h0001;
		case (state_ff)
		ST_IDLE: begin
			nxt_tmr = 16'h0000;
			if (~i_dq_in) begin
				// standard speed adds a low-pass qualifier
				nxt_state = fast_ff ? ST_LOW : ST_FILT;
			end
		end
		ST_FILT: begin
			if (i_dq_in) begin
				nxt_state = ST_IDLE;
			end else if (tmr_ff == FILT_LAST) begin
				nxt_state = ST_LOW;
				nxt_tmr   = FILT_CYC;
			end
		end
		ST_LOW: begin
			if (slot_end) begin
				nxt_state = ST_REH;
				nxt_tmr   = 16'h0000;
			end else if (tmr_ff == 16'hFFFF) begin
				nxt_tmr = tmr_ff;
			end
		end
		ST_REH: begin
			// glitches inside the holdoff cannot restart the timer
			if (tmr_ff == sel_cyc(fast_ff, STD_REH, OD_REH)) begin
				nxt_state = ST_IDLE;
			end
		end
		default: begin
			nxt_state = ST_IDLE;
		end
		endcase
	end

	// slot timer and state registers
	always @(posedge i_clk) begin
		if (i_srst) begin
			state_ff <= ST_IDLE;
			tmr_ff   <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			tmr_ff   <= nxt_tmr;
		end
	end

	// open-drain pulldown for a zero reply, released by the timer
	always @(posedge i_clk) begin
		if (i_srst) begin
			drive_ff <= 1'b0;
		end else if (nxt_state == ST_LOW && state_ff != ST_LOW) begin
			drive_ff <= sh_full_ff & ~sh_ff[0];
		end else if (state_ff == ST_LOW && tmr_ff == end_cyc) begin
			drive_ff <= 1'b0;
		end
	end

	// transmit shifter: data bytes, then complemented crc low byte first
	always @(posedge i_clk) begin
		if (i_srst) begin
			sh_ff       <= 8'h00;
			bitn_ff     <= 3'd0;
			sh_full_ff  <= 1'b0;
			crc_left_ff <= 2'd0;
			crc_hi_ff   <= 8'h00;
			o_crc_sent  <= 1'b0;
		end else begin
			o_crc_sent <= 1'b0;
			if (sh_full_ff && sample_pt) begin
				// one bit leaves per slot, lsb first
				sh_ff   <= {1'b0, sh_ff[7:1]};
				bitn_ff <= bitn_ff + 3'd1;
				if (bitn_ff == 3'd7) begin
					sh_full_ff <= 1'b0;
				end
			end else if (!sh_full_ff && crc_left_ff == 2'd1 &&
				state_ff == ST_IDLE) begin
				sh_ff       <= crc_hi_ff;
				sh_full_ff  <= 1'b1;
				crc_left_ff <= 2'd0;
				o_crc_sent  <= 1'b1;
			end else if (crc_due && !sh_full_ff && !fifo_rvalid) begin
				sh_ff       <= ~crc_val[7:0];
				crc_hi_ff   <= ~crc_val[15:8];
				sh_full_ff  <= 1'b1;
				crc_left_ff <= 2'd1;
			end else if (load_sh) begin
				sh_ff      <= fifo_rdata;
				sh_full_ff <= 1'b1;
				bitn_ff    <= 3'd0;
			end
		end
	end

	// write bits sampled at the internal sample point
	always @(posedge i_clk) begin
		if (i_srst) begin
			o_wbit_valid <= 1'b0;
			o_wbit       <= 1'b0;
			o_tx_busy    <= 1'b0;
		end else begin
			o_wbit_valid <= sample_pt & ~sh_full_ff;
			o_tx_busy    <= sh_full_ff | (crc_left_ff != 2'd0);
			if (sample_pt && !sh_full_ff) begin
				o_wbit <= i_dq_in;
			end
		end
	end

	// crc session bookkeeping
	always @(posedge i_clk) begin
		if (i_srst) begin
			crc_act_ff <= 1'b0;
			kind_ff    <= `SWSC_K_RMC_FIRST;
		end else if (i_crc_start) begin
			// a new session always wins over the end of the old one
			crc_act_ff <= 1'b1;
			kind_ff    <= i_crc_kind;
		end else if (o_crc_sent) begin
			crc_act_ff <= 1'b0;
		end
	end

	// long low is a reset: >=690us drops fast speed, short keeps it
	always @(posedge i_clk) begin
		if (i_srst) begin
			fast_ff    <= 1'b0;
			rst_rep_ff <= 1'b0;
		end else begin
			rst_rep_ff <= 1'b0;
			if (state_ff == ST_LOW && tmr_ff == RST_CYC) begin
				fast_ff    <= 1'b0;
				rst_rep_ff <= 1'b1;
			end else if (i_fast_speed_set) begin
				fast_ff <= 1'b1;
			end
		end
	end
endmodule // swsc_slot

// *** core/swsc_defs.vh ***
// timing, crc and command constants for the single-wire slot and crc block
`ifndef SWSC_DEFS_VH
`define SWSC_DEFS_VH

// clock rate in kHz (20 MHz)
`define SWSC_CLK_KHZ            20000
// times in ns, standard speed
`define SWSC_STD_SAMPLE_NS      30000
`define SWSC_STD_READ_HOLD_NS   30000
`define SWSC_STD_FILTER_NS      1000
`define SWSC_STD_REH_NS         5000
// times in ns, overdrive speed
`define SWSC_OD_SAMPLE_NS       3000
`define SWSC_OD_READ_HOLD_NS    3000
`define SWSC_OD_REH_NS          2000
// reset low times in us
`define SWSC_RST_EXIT_OD_US     690
`define SWSC_RST_KEEP_OD_US     80
// cycle counts, least times round up
`define SWSC_NS2CYC(ns)         (((ns) * 20 + 999) / 1000)
`define SWSC_US2CYC(us)         ((us) * 20)
`define SWSC_STD_SAMPLE_CYC     `SWSC_NS2CYC(`SWSC_STD_SAMPLE_NS)
`define SWSC_STD_HOLD_CYC       `SWSC_NS2CYC(`SWSC_STD_READ_HOLD_NS)
`define SWSC_STD_FILT_CYC       `SWSC_NS2CYC(`SWSC_STD_FILTER_NS)
`define SWSC_STD_REH_CYC        `SWSC_NS2CYC(`SWSC_STD_REH_NS)
`define SWSC_OD_SAMPLE_CYC      `SWSC_NS2CYC(`SWSC_OD_SAMPLE_NS)
`define SWSC_OD_HOLD_CYC        `SWSC_NS2CYC(`SWSC_OD_READ_HOLD_NS)
`define SWSC_OD_REH_CYC         `SWSC_NS2CYC(`SWSC_OD_REH_NS)
`define SWSC_RST_EXIT_CYC       `SWSC_US2CYC(`SWSC_RST_EXIT_OD_US)
// crc reset value and reflected polynomial of x^16+x^15+x^2+1
`define SWSC_CRC_INIT           16'h0000
`define SWSC_CRC_POLY           16'hA001
// scratchpad last offset 11111b
`define SWSC_SP_LAST            5'h1F
// crc session kinds
`define SWSC_K_RMC_FIRST        2'd0
`define SWSC_K_RMC_NEXT         2'd1
`define SWSC_K_WS               2'd2
`define SWSC_K_RS               2'd3
// fifo shape
`define SWSC_FIFO_W             8
`define SWSC_FIFO_D             4
`define SWSC_FIFO_AW            2

`endif

// *** core/swsc_fifo.v ***
// small valid/ready fifo holding outgoing bytes
`timescale 1ns/10ps
module swsc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             i_clk,
	input  wire             i_srst,
	input  wire             i_wvalid,
	output wire             o_wready,
	input  wire [WIDTH-1:0] i_wdata,
	output wire             o_rvalid,
	input  wire             i_rready,
	output reg  [WIDTH-1:0] o_rdata
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wptr_ff;
	reg [AW-1:0]    rptr_ff;
	reg [AW:0]      cnt_ff;
	wire            do_w;
	wire            do_r;

	// full and empty come straight from the occupancy count
	assign o_wready = (cnt_ff != DEPTH[AW:0]);
	assign o_rvalid = (cnt_ff != {(AW+1){1'b0}});
	assign do_w     = i_wvalid & o_wready;
	assign do_r     = o_rvalid & i_rready;

	// storage write
	always @(posedge i_clk) begin
		if (do_w) begin
			mem_ff[wptr_ff] <= i_wdata;
		end
	end

	// read data taken combinationally from the head entry, not registered
	always @* begin
		o_rdata = mem_ff[rptr_ff];
	end

	// pointers and count
	always @(posedge i_clk) begin
		if (i_srst) begin
			wptr_ff <= {AW{1'b0}};
			rptr_ff <= {AW{1'b0}};
			cnt_ff  <= {(AW+1){1'b0}};
		end else begin
			if (do_w) begin
				wptr_ff <= wptr_ff + 1'b1;
			end
			if (do_r) begin
				rptr_ff <= rptr_ff + 1'b1;
			end
			if (do_w & ~do_r) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (do_r & ~do_w) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end
endmodule // swsc_fifo

// *** core/swsc_crc16.v ***
// byte-wide crc-16 generator, lsb first
`timescale 1ns/10ps
module swsc_crc16 (
	input  wire        i_clk,
	input  wire        i_srst,
	input  wire        i_clear,
	input  wire        i_shift,
	input  wire [7:0]  i_byte,
	output reg  [15:0] o_crc
);
	`include "swsc_defs.vh"

	// one byte through the reflected generator, bit 0 first
	function [15:0] crc_byte;
		input [15:0] c;
		input [7:0]  b;
		integer      k;
		reg   [15:0] t;
		begin
			t = c;
			for (k = 0; k < 8; k = k + 1) begin
				if (t[0] ^ b[k]) begin
					t = (t >> 1) ^ `SWSC_CRC_POLY;
				end else begin
					t = t >> 1;
				end
			end
			crc_byte = t;
		end
	endfunction

	// clear wins, then a byte shifts in
	always @(posedge i_clk) begin
		if (i_srst | i_clear) begin
			o_crc <= `SWSC_CRC_INIT;
		end else if (i_shift) begin
			o_crc <= crc_byte(o_crc, i_byte);
		end
	end
endmodule // swsc_crc16

// *** test/swsc_slot_props.sv ***
// checker for the slot engine ports
`timescale 1ns/10ps
module swsc_slot_props (
	input wire i_clk,
	input wire i_srst,
	input wire i_dq_in,
	input wire o_dq_oe_n,
	input wire i_fast_speed_set,
	input wire o_fast_speed_flag,
	input wire o_reset_seen,
	input wire o_wbit_valid,
	input wire o_wbit
);
	reg        dq_ff;
	reg [15:0] fall_ff;
	reg [15:0] run_ff;
	reg [15:0] oe_ff;
	wire       fast = o_fast_speed_flag;

	// cycles since the line fell, length of the last low, pulldown length
	always @(posedge i_clk) begin
		dq_ff   <= i_dq_in;
		fall_ff <= (dq_ff && !i_dq_in) ? 16'h0000 : fall_ff + 16'h0001;
		run_ff  <= i_dq_in ? run_ff : (dq_ff ? 16'h0001 : run_ff + 16'h0001);
		oe_ff   <= o_dq_oe_n ? 16'h0000 : oe_ff + 16'h0001;
	end

	default clocking dcb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	property p_one_bit;
		o_wbit_valid |=> !o_wbit_valid [*8];
	endproperty
	a_one_bit: assert property (p_one_bit)
		else $error("write bit pulse repeats");

	// window around the sample point; the registered valid comes one cycle after it
	property p_sample;
		o_wbit_valid |-> (fast ? (fall_ff >= 16'h0037 && fall_ff <= 16'h0044)
			: (fall_ff >= 16'h0253 && fall_ff <= 16'h0276));
	endproperty
	a_sample: assert property (p_sample)
		else $error("write bit sampled off time");

	property p_wbit_level;
		o_wbit_valid |-> o_wbit == $past(i_dq_in);
	endproperty
	a_wbit_level: assert property (p_wbit_level)
		else $error("write bit not the line level");

	property p_pull_start;
		$fell(o_dq_oe_n) |-> !$past(i_dq_in);
	endproperty
	a_pull_start: assert property (p_pull_start)
		else $error("pulldown began on a high line");

	property p_pull_len;
		$rose(o_dq_oe_n) |-> (fast ? (oe_ff > 16'h0064 && oe_ff <= 16'h007D)
			: (oe_ff > 16'h044C && oe_ff <= 16'h04B5));
	endproperty
	a_pull_len: assert property (p_pull_len)
		else $error("pulldown length wrong");

	property p_filter;
		$fell(o_dq_oe_n) && !fast |-> run_ff >= 16'h0014;
	endproperty
	a_filter: assert property (p_filter)
		else $error("slot taken before filter time");

	property p_fast_enter;
		$rose(o_fast_speed_flag) |-> $past(i_fast_speed_set);
	endproperty
	a_fast_enter: assert property (p_fast_enter)
		else $error("fast timing without request");

	property p_fast_exit;
		$fell(o_fast_speed_flag) |-> o_reset_seen || $past(o_reset_seen);
	endproperty
	a_fast_exit: assert property (p_fast_exit)
		else $error("fast timing left without long reset");

	property p_reset_len;
		o_reset_seen |-> run_ff >= 16'h35E8;
	endproperty
	a_reset_len: assert property (p_reset_len)
		else $error("reset flagged on short low");
endmodule // swsc_slot_props

bind swsc_slot swsc_slot_props u_props (
	.i_clk(i_clk), .i_srst(i_srst), .i_dq_in(i_dq_in),
	.o_dq_oe_n(o_dq_oe_n), .i_fast_speed_set(i_fast_speed_set),
	.o_fast_speed_flag(o_fast_speed_flag), .o_reset_seen(o_reset_seen),
	.o_wbit_valid(o_wbit_valid), .o_wbit(o_wbit));

// *** test/swsc_master_model.sv ***
// behavioural bus master driving slots on the pulled-up line
`timescale 1ns/10ps
module swsc_master_model (
	input  wire i_clk,
	input  wire i_fast,
	input  wire i_slave_oe_n,
	output wire o_line
);
	reg     pull_ff = 1'b0;
	integer glitch_len = 0;

	// open-drain line: low while either party pulls, else the pull-up wins
	assign o_line = !(pull_ff || !i_slave_oe_n);

	// one slot; a set glitch_len adds a short low inside the slave's recovery holdoff
	task slot(input reg zero, output reg b);
		integer t, tl, ts, tt, gs;
		begin
			// glitch lands just after the slave's slot timer has run out
			gs = i_fast ? 130 : 1220;
			tl = zero ? (i_fast ? 80 : 800) : (i_fast ? 10 : 40);
			ts = i_fast ? 30 : 300;
			tt = i_fast ? 180 : 1500;
			b = 1'b1;
			for (t = 0; t < tt; t = t + 1) begin
				@(posedge i_clk);
				if (t == ts)
					b = o_line;
				#2 pull_ff = t < tl || (t >= gs && t < gs + glitch_len);
			end
		end
	endtask

	// a byte lsb first; ones double as read slots
	task xfer(input reg [7:0] wr, output reg [7:0] rd);
		integer i;
		reg     b;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				slot(!wr[i], b);
				rd[i] = b;
			end
		end
	endtask

	// plain low pulse followed by a generous recovery
	task low(input integer n);
		begin
			@(posedge i_clk);
			#2 pull_ff = 1'b1;
			repeat (n) @(posedge i_clk);
			#2 pull_ff = 1'b0;
			repeat (400) @(posedge i_clk);
		end
	endtask
endmodule // swsc_master_model

// *** test/tb_single_wire_slot_crc.sv ***
// bench for the slot engine with a behavioural bus master
`timescale 1ns/10ps
module tb_single_wire_slot_crc;
	reg        clk = 1'b0, srst = 1'b1, fs = 1'b0, tv = 1'b0, cst = 1'b0;
	reg        cv = 1'b0, cp = 1'b0, csend = 1'b0, fast = 1'b0;
	reg  [7:0] tx = 8'h00, cb = 8'h00, wq = 8'h00;
	reg  [1:0] ck = 2'h0;
	reg  [4:0] so = 5'h00;
	integer    fail_count = 0, tests_run = 0, wn = 0, rn = 0, cn = 0;
	wire       dq, oe_n, flag, rs, wv, wb, rdy, busy, cs;

	swsc_slot uut (
		.i_clk(clk), .i_srst(srst), .i_dq_in(dq), .o_dq_out(),
		.o_dq_oe_n(oe_n), .i_fast_speed_set(fs), .o_fast_speed_flag(flag),
		.o_reset_seen(rs), .o_wbit_valid(wv), .o_wbit(wb),
		.i_tx_valid(tv), .o_tx_ready(rdy), .i_tx_byte(tx), .o_tx_busy(busy),
		.i_crc_start(cst), .i_crc_kind(ck), .i_crc_byte_valid(cv),
		.i_crc_byte(cb), .i_crc_is_pw(cp), .i_sp_offset(so),
		.i_crc_send(csend), .o_crc_sent(cs));
	swsc_master_model mdl (.i_clk(clk), .i_fast(fast), .i_slave_oe_n(oe_n),
		.o_line(dq));

	always #25 clk = ~clk;

	// gather write bits lsb first; drop the crc request once it is taken
	always @(posedge clk) begin
		if (wv) begin
			wq <= {wb, wq[7:1]};
			wn <= wn + 1;
		end
		if (rs)
			rn <= rn + 1;
		if (cs) begin
			cn <= cn + 1;
			csend <= 1'b0;
		end
	end

	task chk(input string nm, input [15:0] e, input [15:0] g);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("FAIL %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask

	function [15:0] crc_add(input [15:0] c, input [7:0] d);
		integer k;
		begin
			crc_add = c;
			for (k = 0; k < 8; k = k + 1)
				crc_add = (crc_add >> 1) ^ ((crc_add[0] ^ d[k]) ? 16'hA001 : 16'h0000);
		end
	endfunction

	// ready is steady between edges, so it is read before the taking edge
	task push(input [7:0] d, output reg ok);
		begin
			@(posedge clk);
			#2 tv = 1'b1;
			tx = d;
			ok = rdy;
			@(posedge clk);
			#2 tv = 1'b0;
		end
	endtask

	task t_reset;
		begin
			chk("oe_n", 16'h0001, {15'h0000, oe_n});
			chk("flag", 16'h0000, {15'h0000, flag});
		end
	endtask

	task t_write(input [7:0] v);
		integer n0;
		reg [7:0] r;
		begin
			n0 = wn;
			mdl.xfer(v, r);
			chk("bits", n0[15:0] + 16'h0008, wn[15:0]);
			chk("wbyte", {8'h00, v}, {8'h00, wq});
		end
	endtask

	task t_read(input [7:0] v);
		reg ok;
		reg [7:0] r;
		begin
			push(v, ok);
			mdl.xfer(8'hFF, r);
			chk("rbyte", {8'h00, v}, {8'h00, r});
		end
	endtask

	task t_filter;
		integer n0;
		begin
			n0 = wn;
			mdl.low(10);
			chk("filter", n0[15:0], wn[15:0]);
		end
	endtask

	task t_fast;
		begin
			@(posedge clk);
			#2 fs = 1'b1;
			@(posedge clk);
			#2 fs = 1'b0;
			fast = 1'b1;
			@(posedge clk);
			chk("fast", 16'h0001, {15'h0000, flag});
		end
	endtask

	task t_holdoff;
		integer n0;
		reg [7:0] r;
		begin
			n0 = wn;
			mdl.glitch_len = 10;
			mdl.xfer(8'h00, r);
			mdl.glitch_len = 0;
			chk("glitch", n0[15:0] + 16'h0008, wn[15:0]);
		end
	endtask

	// fill while the master stalls: four queued plus one in the shifter
	task t_fifo;
		integer i, k;
		reg ok;
		reg [7:0] r;
		begin
			k = 0;
			for (i = 0; i < 6; i = i + 1) begin
				push(8'hC3 ^ i[7:0], ok);
				k = k + ok;
			end
			chk("accepted", 16'h0005, k[15:0]);
			for (i = 0; i < 5; i = i + 1) begin
				mdl.xfer(8'hFF, r);
				chk("fbyte", {8'h00, 8'hC3 ^ i[7:0]}, {8'h00, r});
			end
			chk("busy", 16'h0000, {15'h0000, busy});
			mdl.xfer(8'hFF, r);
			chk("empty", 16'h00FF, {8'h00, r});
		end
	endtask

	task t_crc(input [1:0] kind, input [4:0] off);
		integer i, n0;
		reg [15:0] c;
		reg [7:0] b, lo, hi;
		begin
			@(posedge clk);
			#2 ck = kind;
			so = off;
			cst = 1'b1;
			c = 16'h0000;
			for (i = 0; i < 12; i = i + 1) begin
				b = i[7:0] * 8'h25 + 8'h0F;
				@(posedge clk);
				#2 cst = 1'b0;
				cv = 1'b1;
				cb = b;
				cp = kind == 2'h0 && i > 2 && i < 11;
				if (!cp)
					c = crc_add(c, b);
			end
			@(posedge clk);
			#2 cv = 1'b0;
			cp = 1'b0;
			n0 = cn;
			csend = 1'b1;
			if (off != 5'h1F) begin
				repeat (400) @(posedge clk);
				chk("held", n0[15:0], cn[15:0]);
				#2 so = 5'h1F;
			end
			mdl.xfer(8'hFF, lo);
			mdl.xfer(8'hFF, hi);
			chk("crc", ~c, {hi, lo});
			chk("sent", n0[15:0] + 16'h0001, cn[15:0]);
		end
	endtask

	task t_rst;
		integer n0;
		begin
			mdl.low(1600);
			chk("kept", 16'h0001, {15'h0000, flag});
			n0 = rn;
			mdl.low(14000);
			fast = 1'b0;
			chk("rseen", n0[15:0] + 16'h0001, rn[15:0]);
			chk("left", 16'h0000, {15'h0000, flag});
		end
	endtask

	task wrap_up;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, fail_count);
			if (fail_count == 0 && tests_run > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask

	// main sequence: standard speed first, then fast, then back
	initial begin
		repeat (2) @(posedge clk);
		#2 srst = 1'b0;
		t_reset;
		t_write(8'hA5);
		t_read(8'h3C);
		t_filter;
		t_fast;
		t_write(8'h96);
		t_holdoff;
		t_fifo;
		t_crc(2'h2, 5'h1F);
		t_crc(2'h0, 5'h1F);
		t_crc(2'h1, 5'h1F);
		t_crc(2'h3, 5'h1E);
		t_rst;
		t_write(8'h0F);
		wrap_up;
	end

	// about 90000 cycles, past the expected run of some 77000
	initial begin
		#4500000;
		fail_count = fail_count + 1;
		wrap_up;
	end
endmodule // tb_single_wire_slot_crc
